// *** design/nfsr_ctrl.v ***
// Functional notes
// - host waits 30 us from resume to suspend
// - host never protects/unprotects while suspended
// - 200 ns wake-up after reset pin rises
// - write only with chip select, strobe low, output-enable high
// - lock bit programmed, then wait over 100 us
`timescale 1ns/10ps
`default_nettype none
`include "nfsr_map.vh"
module nfsr_ctrl #(
    parameter AW = 24,
    parameter DW = 16,
    parameter RESET_PULSE_NS = `NFSR_RESET_PULSE_NS
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output reg o_pslverr,
    // flash pins
    output reg o_ce_b,
    output reg o_oe_b,
    output reg o_we_b,
    output reg o_flash_reset_b,
    output reg o_write_protect_accel_pin,
    output reg [AW-1:0] o_addr,
    input wire [DW-1:0] i_dq,
    output reg [DW-1:0] o_dq,
    output reg o_dq_oe
);
    localparam integer GAP_I = `NFSR_CYC_UP(`NFSR_RESUME_GAP_NS);
    localparam integer LOCK_I = `NFSR_CYC_UP(`NFSR_LOCK_NS) + 1;
    localparam integer WAKE_I = `NFSR_CYC_UP(`NFSR_WAKE_NS);
    localparam integer TRP_I = `NFSR_CYC_UP(RESET_PULSE_NS);
    localparam integer STB_I = `NFSR_CYC_UP(`NFSR_STROBE_NS);
    localparam [11:0] CYC_GAP = GAP_I[11:0];
    localparam [11:0] CYC_LOCK = LOCK_I[11:0];
    localparam [11:0] CYC_WAKE = WAKE_I[11:0];
    localparam [11:0] CYC_TRP = TRP_I[11:0];
    localparam [11:0] CYC_STB = STB_I[11:0];
    localparam [11:0] CNT_ONE = 12'h001;
    localparam [11:0] CNT_ZERO = 12'h000;
    // controller states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_GAP = 3'h1;
    localparam [2:0] ST_SETUP = 3'h2;
    localparam [2:0] ST_STROBE = 3'h3;
    localparam [2:0] ST_HOLD = 3'h4;
    localparam [2:0] ST_POST = 3'h5;
    localparam [2:0] ST_RSTLO = 3'h6;
    localparam [2:0] ST_WAKE = 3'h7;

    reg [2:0] state;
    reg [2:0] op;
    reg [11:0] cnt;
    reg [11:0] gap_cnt;
    reg [AW-1:0] addr;
    reg [DW-1:0] wdata;
    reg [DW-1:0] rdata;
    reg suspended;
    reg refused;
    reg [DW-1:0] dq_s1;
    reg [DW-1:0] dq_s2;

    wire busy = (state != ST_IDLE);
    wire apb_wr = i_psel & i_penable & i_pwrite;
    wire cmd_wr = apb_wr & (i_paddr == `NFSR_OFF_CMD);
    wire st_wr = apb_wr & (i_paddr == `NFSR_OFF_STATUS);
    wire [2:0] new_op = i_pwdata[2:0];
    wire op_is_write = (op != `NFSR_OP_READ);
    wire [`NFSR_ST_WIDTH-1:0] status_bits = {gap_cnt != CNT_ZERO, refused, suspended, busy};

    function is_unmapped;
        input [11:0] a;
        begin
            is_unmapped = (a != `NFSR_OFF_CONFIG) && (a != `NFSR_OFF_ADDR) && (a != `NFSR_OFF_WDATA) &&
                (a != `NFSR_OFF_CMD) && (a != `NFSR_OFF_RDATA) && (a != `NFSR_OFF_STATUS);
        end
    endfunction

    // slave answers in the access cycle, never stalls
    assign o_pready = 1'b1;

    // read mux, unmapped reads return zero with an error
    always @* begin
        o_prdata = 32'h00000000;
        o_pslverr = i_psel & i_penable & is_unmapped(i_paddr);
        if (i_paddr == `NFSR_OFF_CONFIG) begin
            o_prdata[`NFSR_CFG_WP_BIT] = o_write_protect_accel_pin;
        end else if (i_paddr == `NFSR_OFF_ADDR) begin
            o_prdata[AW-1:0] = addr;
        end else if (i_paddr == `NFSR_OFF_WDATA) begin
            o_prdata[DW-1:0] = wdata;
        end else if (i_paddr == `NFSR_OFF_CMD) begin
            o_prdata[2:0] = op;
        end else if (i_paddr == `NFSR_OFF_RDATA) begin
            o_prdata[DW-1:0] = rdata;
        end else if (i_paddr == `NFSR_OFF_STATUS) begin
            o_prdata[`NFSR_ST_WIDTH-1:0] = status_bits;
        end
    end

    // data pins come from outside the clock domain
    always @(posedge i_clk_sys) begin
        dq_s1 <= i_dq;
        dq_s2 <= dq_s1;
    end

    // config registers; wp level is software's, low guards the end block
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_write_protect_accel_pin <= 1'b0;
            addr <= {AW{1'b0}};
            wdata <= {DW{1'b0}};
        end else if (apb_wr) begin
            if (i_paddr == `NFSR_OFF_CONFIG) begin
                o_write_protect_accel_pin <= i_pwdata[`NFSR_CFG_WP_BIT];
            end else if (i_paddr == `NFSR_OFF_ADDR) begin
                addr <= i_pwdata[AW-1:0];
            end else if (i_paddr == `NFSR_OFF_WDATA) begin
                wdata <= i_pwdata[DW-1:0];
            end
        end
    end

    // bus cycle sequencer; flash reset pin held low through system reset
    always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state <= ST_WAKE;
            cnt <= CYC_WAKE;
            op <= `NFSR_OP_WRITE;
            gap_cnt <= CNT_ZERO;
            rdata <= {DW{1'b0}};
            suspended <= 1'b0;
            refused <= 1'b0;
            o_ce_b <= 1'b1;
            o_oe_b <= 1'b1;
            o_we_b <= 1'b1;
            o_flash_reset_b <= 1'b0;
            o_addr <= {AW{1'b0}};
            o_dq <= {DW{1'b0}};
            o_dq_oe <= 1'b0;
        end else begin
            // resume-to-suspend spacing timer
            if (gap_cnt != CNT_ZERO) begin
                gap_cnt <= gap_cnt - CNT_ONE;
            end
            // software clear of refused; a new refusal below wins
            if (st_wr && i_pwdata[`NFSR_ST_REFUSED_BIT]) begin
                refused <= 1'b0;
            end
            if (!o_flash_reset_b) begin
                o_flash_reset_b <= (state == ST_RSTLO) ? 1'b0 : 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        op <= new_op;
                        if (new_op == `NFSR_OP_HWRESET) begin
                            o_flash_reset_b <= 1'b0;
                            cnt <= CYC_TRP;
                            state <= ST_RSTLO;
                        end else if (((new_op == `NFSR_OP_PROTECT) || (new_op == `NFSR_OP_LOCK)) && suspended) begin
                            refused <= 1'b1;
                        end else if ((new_op == `NFSR_OP_SUSPEND) && (gap_cnt != CNT_ZERO)) begin
                            state <= ST_GAP;
                        end else begin
                            state <= ST_SETUP;
                        end
                    end
                end
                ST_GAP: begin
                    if (gap_cnt == CNT_ZERO) begin
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // address and data settle before the strobe falls
                    o_ce_b <= 1'b0;
                    o_addr <= (op == `NFSR_OP_QUERY) ? `NFSR_QUERY_ADDR : addr;
                    o_dq <= (op == `NFSR_OP_QUERY) ? `NFSR_QUERY_DATA : wdata;
                    o_dq_oe <= op_is_write;
                    cnt <= CYC_STB;
                    state <= ST_STROBE;
                end
                ST_STROBE: begin
                    o_we_b <= ~op_is_write;
                    o_oe_b <= op_is_write;
                    // count runs down to zero so the strobe stands the full CYC_STB cycles
                    if (cnt != CNT_ZERO) begin
                        cnt <= cnt - CNT_ONE;
                    end
                    if (cnt == CNT_ZERO) begin
                        // synced data lags two cycles; strobe is longer than that
                        if (!op_is_write) begin
                            rdata <= dq_s2;
                        end
                        o_we_b <= 1'b1;
                        o_oe_b <= 1'b1;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    o_ce_b <= 1'b1;
                    o_dq_oe <= 1'b0;
                    state <= ST_IDLE;
                    if (op == `NFSR_OP_SUSPEND) begin
                        suspended <= 1'b1;
                    end else if (op == `NFSR_OP_RESUME) begin
                        suspended <= 1'b0;
                        gap_cnt <= CYC_GAP;
                    end else if (op == `NFSR_OP_LOCK) begin
                        cnt <= CYC_LOCK;
                        state <= ST_POST;
                    end
                end
                ST_POST: begin
                    // lock programming runs; controller stays busy past the minimum
                    cnt <= cnt - CNT_ONE;
                    if (cnt == CNT_ONE) begin
                        state <= ST_IDLE;
                    end
                end
                ST_RSTLO: begin
                    cnt <= cnt - CNT_ONE;
                    if (cnt == CNT_ONE) begin
                        o_flash_reset_b <= 1'b1;
                        suspended <= 1'b0;
                        gap_cnt <= CNT_ZERO;
                        cnt <= CYC_WAKE;
                        state <= ST_WAKE;
                    end
                end
                default: begin
                    // wake-up: no read may start until the count ends
                    o_flash_reset_b <= 1'b1;
                    cnt <= cnt - CNT_ONE;
                    if (cnt == CNT_ONE) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
            // a command while busy is dropped and flagged
            if (cmd_wr && busy) begin
                refused <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** pkg/nfsr_map.vh ***
`ifndef NFSR_MAP_VH
`define NFSR_MAP_VH
// apb register byte offsets
`define NFSR_OFF_CONFIG 12'h000
`define NFSR_OFF_ADDR 12'h004
`define NFSR_OFF_WDATA 12'h008
`define NFSR_OFF_CMD 12'h00c
`define NFSR_OFF_RDATA 12'h010
`define NFSR_OFF_STATUS 12'h014
// field positions
`define NFSR_CFG_WP_BIT 0
`define NFSR_ST_BUSY_BIT 0
`define NFSR_ST_SUSP_BIT 1
`define NFSR_ST_REFUSED_BIT 2
`define NFSR_ST_GAP_BIT 3
`define NFSR_ST_WIDTH 4
// operation codes written to the command register
`define NFSR_OP_WRITE 3'h0
`define NFSR_OP_READ 3'h1
`define NFSR_OP_SUSPEND 3'h2
`define NFSR_OP_RESUME 3'h3
`define NFSR_OP_PROTECT 3'h4
`define NFSR_OP_LOCK 3'h5
`define NFSR_OP_QUERY 3'h6
`define NFSR_OP_HWRESET 3'h7
// query entry cycle
`define NFSR_QUERY_DATA 16'h0098
`define NFSR_QUERY_ADDR 24'h000055
// timing, in nanoseconds, and the clock period
`define NFSR_CLK_NS 50
`define NFSR_RESUME_GAP_NS 30000
`define NFSR_LOCK_NS 100000
`define NFSR_WAKE_NS 200
`define NFSR_RESET_PULSE_NS 500
`define NFSR_STROBE_NS 200
// least times round up to whole cycles
`define NFSR_CYC_UP(ns) (((ns) + `NFSR_CLK_NS - 1) / `NFSR_CLK_NS)
`endif

// *** tb/nfsr_ctrl_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "nfsr_map.vh"
module nfsr_ctrl_checker #(parameter AW = 24, parameter DW = 16) (
    // apb side
    input wire logic i_clk_sys, i_rst_b, i_psel, i_penable, i_pwrite, o_pready, o_pslverr,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata, o_prdata,
    // flash pins
    input wire logic o_ce_b, o_oe_b, o_we_b, o_flash_reset_b, o_write_protect_accel_pin, o_dq_oe,
    input wire logic [AW-1:0] o_addr,
    input wire logic [DW-1:0] i_dq, o_dq
);
    logic [2:0] last_op;
    logic [9:0] gap;
    // cycles since the resume strobe; saturates so an old resume never matters
    always @(posedge i_clk_sys) begin
        if (!i_rst_b || !o_flash_reset_b) begin
            last_op <= 3'h0;
            gap <= 10'h3ff;
        end else begin
            if (i_psel && i_penable && i_pwrite && i_paddr == `NFSR_OFF_CMD) last_op <= i_pwdata[2:0];
            if (!o_we_b && last_op == `NFSR_OP_RESUME) gap <= 10'h000;
            else if (gap != 10'h3ff) gap <= gap + 10'h001;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    AST_WE_QUAL: assert property (!o_we_b |-> !o_ce_b && o_oe_b) else $error("bad write qualifiers");
    AST_NO_FIGHT: assert property (!o_oe_b |-> !o_dq_oe && o_we_b) else $error("dq driven in read");
    AST_STROBE: assert property ($fell(o_we_b) |-> !o_we_b[*4] ##1 o_we_b) else $error("strobe width");
    AST_HOLD: assert property (!o_we_b |-> $stable(o_addr) && $stable(o_dq)) else $error("addr moved");
    AST_WAKE: assert property ($rose(o_flash_reset_b) |-> o_ce_b[*4]) else $error("access in wake");
    AST_PULSE: assert property ($fell(o_flash_reset_b) |-> !o_flash_reset_b[*8] ##1 !o_flash_reset_b
        ##1 !o_flash_reset_b) else $error("reset pulse short");
    AST_QUIET: assert property (!o_flash_reset_b |-> o_ce_b && o_we_b) else $error("access in reset");
    AST_GAP: assert property ($fell(o_we_b) && last_op == `NFSR_OP_SUSPEND |-> gap >= 10'd600)
        else $error("suspend too soon");
endmodule
bind nfsr_ctrl nfsr_ctrl_checker #(.AW(AW), .DW(DW)) u_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_ce_b(o_ce_b), .o_oe_b(o_oe_b),
    .o_we_b(o_we_b), .o_flash_reset_b(o_flash_reset_b), .o_dq_oe(o_dq_oe), .o_addr(o_addr),
    .o_write_protect_accel_pin(o_write_protect_accel_pin), .i_dq(i_dq), .o_dq(o_dq));
`default_nettype wire

// *** tb/nfsr_ctrl_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "nfsr_map.vh"
module nfsr_ctrl_test;
    typedef struct packed {logic [2:0] op; logic [23:0] a; logic [15:0] d; logic wp; logic [15:0] e;} nfsr_row_t;
    logic i_clk_sys = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, r;
    logic o_pready, o_pslverr, o_ce_b, o_oe_b, o_we_b, o_flash_reset_b, o_wp, o_dq_oe, m_en, err;
    logic [23:0] o_addr;
    logic [15:0] o_dq, m_dq, dq_bus;
    int bad_count = 0, n_tests = 0, cyc = 0, t0;
    // writes, end-block protection both ways, query and its exit
    nfsr_row_t rows [10] = '{'{`NFSR_OP_WRITE, 24'h000001, 16'h1234, 1'b1, 16'h0},
        '{`NFSR_OP_READ, 24'h000001, 16'h0, 1'b1, 16'h1234}, '{`NFSR_OP_WRITE, 24'hff0002, 16'habcd, 1'b0, 16'h0},
        '{`NFSR_OP_READ, 24'hff0002, 16'h0, 1'b0, 16'hffff}, '{`NFSR_OP_WRITE, 24'hff0002, 16'habcd, 1'b1, 16'h0},
        '{`NFSR_OP_READ, 24'hff0002, 16'h0, 1'b1, 16'habcd}, '{`NFSR_OP_QUERY, 24'h0, 16'h0, 1'b1, 16'h0},
        '{`NFSR_OP_READ, 24'h000010, 16'h0, 1'b1, 16'h004a}, '{`NFSR_OP_WRITE, 24'h0, 16'h00f0, 1'b1, 16'h0},
        '{`NFSR_OP_READ, 24'h000001, 16'h0, 1'b1, 16'h1234}};
    always #25 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) cyc <= cyc + 1;
    // both sides driving dq at once is a fight
    always @(negedge i_clk_sys) if (m_en === 1'b1 && o_dq_oe === 1'b1) chk("dq_fight", 32'h0, 32'h1);
    // wire level: the enabled party drives it
    assign dq_bus = o_dq_oe ? o_dq : m_dq;
    nfsr_ctrl u_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_ce_b(o_ce_b), .o_oe_b(o_oe_b), .o_we_b(o_we_b), .o_flash_reset_b(o_flash_reset_b),
        .o_write_protect_accel_pin(o_wp), .o_addr(o_addr), .i_dq(dq_bus), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
    nfsr_flash_model u_flash (.i_ce_b(o_ce_b), .i_oe_b(o_oe_b), .i_we_b(o_we_b), .i_reset_b(o_flash_reset_b),
        .i_wp(o_wp), .i_addr(o_addr), .i_dq(dq_bus), .o_dq(m_dq), .o_dq_en(m_en));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge i_clk_sys);
        i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        // answer read half a cycle early: it is what stands at the sampling edge, free of the edge race
        do begin
            @(negedge i_clk_sys);
            rdy = o_pready;
            r = o_prdata;
            err = o_pslverr;
            @(posedge i_clk_sys);
        end while (rdy !== 1'b1);
        i_psel <= 1'b0; i_penable <= 1'b0;
    endtask
    // load the registers, start an op, poll busy under a bound
    task automatic run(input logic [2:0] op, input logic [23:0] a, input logic [15:0] d, input logic wp);
        apb(1'b1, `NFSR_OFF_CONFIG, {31'h0, wp});
        apb(1'b1, `NFSR_OFF_ADDR, {8'h00, a});
        apb(1'b1, `NFSR_OFF_WDATA, {16'h0, d});
        apb(1'b1, `NFSR_OFF_CMD, {29'h0, op});
        wait_idle();
    endtask
    // poll busy; r is preset so status is always read at least once
    task automatic wait_idle();
        r = 32'h1;
        for (int k = 0; k < 1000 && r[0] !== 1'b0; k++) apb(1'b0, `NFSR_OFF_STATUS, 32'h0);
        if (r[0] !== 1'b0) chk("busy", 32'h0, r);
    endtask
    task automatic finish_test;
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        apb(1'b0, `NFSR_OFF_STATUS, 32'h0);
        chk("status", 32'h0, r);
        chk("reset_pin", 32'h1, {31'h0, o_flash_reset_b});
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].a, rows[i].d, rows[i].wp);
            apb(1'b0, `NFSR_OFF_RDATA, 32'h0);
            if (rows[i].op == `NFSR_OP_READ) chk("rdata", {16'h0, rows[i].e}, r);
        end
        run(`NFSR_OP_SUSPEND, 24'h0, 16'h00b0, 1'b1);
        apb(1'b0, `NFSR_OFF_STATUS, 32'h0);
        chk("suspended", 32'h2, r & 32'h6);
        run(`NFSR_OP_PROTECT, 24'h0, 16'h0, 1'b1);
        apb(1'b0, `NFSR_OFF_STATUS, 32'h0);
        chk("protect_refused", 32'h4, r & 32'h4);
        apb(1'b1, `NFSR_OFF_STATUS, 32'h4);
        run(`NFSR_OP_LOCK, 24'h0, 16'hfffe, 1'b1);
        apb(1'b0, `NFSR_OFF_STATUS, 32'h0);
        chk("lock_refused", 32'h4, r & 32'h4);
        apb(1'b1, `NFSR_OFF_STATUS, 32'h4);
        t0 = cyc;
        run(`NFSR_OP_RESUME, 24'h0, 16'h0030, 1'b1);
        run(`NFSR_OP_SUSPEND, 24'h0, 16'h00b0, 1'b1);
        chk("gap", 32'h1, {31'h0, (cyc - t0) >= 600});
        run(`NFSR_OP_HWRESET, 24'h0, 16'h0, 1'b1);
        apb(1'b0, `NFSR_OFF_STATUS, 32'h0);
        chk("hw_reset_clears", 32'h0, r & 32'hf);
        run(`NFSR_OP_QUERY, 24'h0, 16'h0, 1'b1);
        run(`NFSR_OP_HWRESET, 24'h0, 16'h0, 1'b1);
        run(`NFSR_OP_READ, 24'h000010, 16'h0, 1'b1);
        apb(1'b0, `NFSR_OFF_RDATA, 32'h0);
        chk("query_left", 32'h0000ffff, r);
        apb(1'b1, `NFSR_OFF_WDATA, 32'h0000fffe);
        t0 = cyc;
        apb(1'b1, `NFSR_OFF_CMD, {29'h0, `NFSR_OP_LOCK});
        apb(1'b1, `NFSR_OFF_CMD, {29'h0, `NFSR_OP_READ});
        apb(1'b0, `NFSR_OFF_STATUS, 32'h0);
        chk("busy_refused", 32'h5, r & 32'h5);
        wait_idle();
        chk("lock_time", 32'h1, {31'h0, (cyc - t0) > 2001});
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h0, r);
        chk("pslverr", 32'h1, {31'h0, err});
        finish_test;
    end
endmodule
`default_nettype wire

// *** tb/nfsr_flash_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module nfsr_flash_model (
    input wire logic i_ce_b, i_oe_b, i_we_b, i_reset_b, i_wp,
    input wire logic [23:0] i_addr,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic o_dq_en
);
    logic [15:0] mem [0:15];
    logic [15:0] rd;
    logic [15:0] rel = 16'h5a5a;
    logic query = 1'b0;
    logic susp = 1'b0;
    initial for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    // cycles latch on strobe rise only when selected with output enable high
    always @(posedge i_we_b) if (i_reset_b && !i_ce_b && i_oe_b) begin
        if (i_dq == 16'h0098 && i_addr == 24'h000055) query = 1'b1;
        else if (i_dq[7:0] == 8'hf0) query = 1'b0; // address ignored
        else if (i_dq[7:0] == 8'hb0) susp = 1'b1; // takes effect at once, inside any bound
        else if (i_dq[7:0] == 8'h30) susp = 1'b0;
        else if (i_wp || i_addr[23:16] != 8'hff) mem[{i_addr[23], i_addr[2:0]}] = i_dq;
    end
    // reset pin aborts all and drops the extra modes
    always @(negedge i_reset_b) begin
        query = 1'b0;
        susp = 1'b0;
    end
    assign rd = query ? {8'h00, i_addr[7:0] ^ 8'h5a} : mem[{i_addr[23], i_addr[2:0]}];
    // a released bus shows the inverse, so stale data never reads right
    always @(posedge i_oe_b) rel <= ~rd;
    assign o_dq_en = i_reset_b && !i_ce_b && !i_oe_b && i_we_b;
    assign o_dq = o_dq_en ? rd : rel;
endmodule
`default_nettype wire
